// >>> see_asserts.sv
// Concurrent checks on the serial pins and device status.
// Assumes one ref_clk; instantiated beside the interface.
`timescale 1ns/1ps
`default_nettype none
module see_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Serial pins
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sel_b,
  input wire logic pause_b,
  // Device status
  input wire logic active,
  input wire logic write_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic armed;
  // Select low once since reset
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b) armed <= 1'b0;
    else if (!sel_b) armed <= 1'b1;
  sequence s_quiet; sel_b [*2]; endsequence
  sequence s_held; (!pause_b && !sck) [*2]; endsequence
  property p_desel_float; s_quiet |=> !sdo_oe; endproperty
  property p_held_float; s_held |=> !sdo_oe && !active; endproperty
  property p_sdo_fall; sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sck; endproperty
  property p_sdi_stable; $rose(sck) && !sel_b |-> $stable(sdi); endproperty
  property p_sel_sck; $fell(sel_b) |-> $stable(sck); endproperty
  property p_busy_active; write_busy |-> active; endproperty
  property p_standby; sel_b [*4] |-> active == write_busy; endproperty
  property p_selected; (!sel_b && pause_b && armed) [*3] |-> active; endproperty
  property p_unarmed; !armed |-> !sdo_oe && !active; endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("output driven while deselected");
  a_held_float: assert property (p_held_float)
    else $error("output driven or active while paused");
  a_sdo_fall: assert property (p_sdo_fall)
    else $error("output changed while clock high");
  a_sdi_stable: assert property (p_sdi_stable)
    else $error("input changed at clock rise");
  a_sel_sck: assert property (p_sel_sck)
    else $error("clock moved at select");
  a_busy_active: assert property (p_busy_active)
    else $error("write cycle without active state");
  a_standby: assert property (p_standby)
    else $error("no standby while deselected");
  a_selected: assert property (p_selected)
    else $error("selected device not active");
  a_unarmed: assert property (p_unarmed)
    else $error("device answered before first select");
endmodule
`default_nettype wire

// >>> see_device.sv
// SPI EEPROM front end: pin handling, shift logic, array and status.
// Assumes pins synchronous to ref_clk and a clock well faster than sck.
`timescale 1ns/1ps
`default_nettype none
module see_device
  import see_pkg::*;
#(
  parameter int unsigned WRITE_CYC = SEE_WRITE_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Serial pins
  see_if.dev        bus,
  // Status
  output logic      active,
  output logic      write_busy,
  output logic      block_protect_hi,
  output logic      block_protect_lo
);
  initial begin
    if (WRITE_CYC < 1) $error("WRITE_CYC must be at least 1");
  end

  // Main array only; this variant carries no identification page
  logic [7:0]            mem [SEE_ARRAY_BYTES];
  see_dev_state_t        state;
  logic                  sck_q;
  logic                  sel_q;
  logic                  armed;
  logic                  paused;
  logic [2:0]            bit_cnt;
  logic [7:0]            shreg;
  logic [7:0]            cmd;
  logic [15:0]           addr;
  logic                  addr_byte;
  logic [7:0]            txreg;
  logic                  wel;
  logic [7:0]            status;
  logic [7:0]            wbuf;
  logic                  wpend;
  logic [15:0]           wtimer;
  logic                  srwd;
  logic [7:0]            next_byte;

  wire sck_rise  = bus.sck && !sck_q;
  wire sck_fall  = !bus.sck && sck_q;
  wire sel_fall  = !bus.sel_b && sel_q;
  wire live      = armed && !bus.sel_b && !paused;
  wire byte_done = live && sck_rise && (bit_cnt == 3'd7);
  assign next_byte = {shreg[6:0], bus.sdi};

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      sck_q <= bus.sck;
      sel_q <= bus.sel_b;
    end
  end

  // Arming waits for a real falling edge; a low select at reset does not count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed <= 1'b0;
    end else if (sel_fall) begin
      armed <= 1'b1;
    end
  end

  // Pause edges honoured only with sck low, in either mode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      paused <= 1'b0;
    end else if (bus.sel_b) begin
      paused <= 1'b0;
    end else if (!bus.sck) begin
      paused <= !bus.pause_b;
    end
  end

  // Serial receive and command decode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= SEE_D_CMD;
      bit_cnt   <= 3'd0;
      shreg     <= 8'h00;
      cmd       <= 8'h00;
      addr      <= 16'h0000;
      addr_byte <= 1'b0;
    end else if (bus.sel_b || !armed) begin
      state     <= SEE_D_CMD;
      bit_cnt   <= 3'd0;
      addr_byte <= 1'b0;
    end else if (live && sck_rise) begin
      shreg   <= next_byte;
      bit_cnt <= bit_cnt + 3'd1;
      if (bit_cnt == 3'd7) begin
        case (state)
          SEE_D_CMD: begin
            cmd <= next_byte;
            if (next_byte == SEE_CMD_READ || next_byte == SEE_CMD_WRITE) begin
              state <= SEE_D_ADDR;
            end else if (next_byte == SEE_CMD_RDSR) begin
              state <= SEE_D_RDATA;
            end else if (next_byte == SEE_CMD_WRSR) begin
              state <= SEE_D_SRW;
            end else begin
              state <= SEE_D_SINK;
            end
          end
          SEE_D_ADDR: begin
            addr      <= {addr[7:0], next_byte};
            addr_byte <= 1'b1;
            if (addr_byte) begin
              state <= (cmd == SEE_CMD_READ) ? SEE_D_RDATA : SEE_D_WDATA;
            end
          end
          SEE_D_RDATA: begin
            if (cmd == SEE_CMD_READ) begin
              addr <= addr + 16'd1;
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end
    end
  end

  // Output shifter moves on sck falling edge only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      txreg <= 8'h00;
    end else if (live && sck_fall && state == SEE_D_RDATA) begin
      if (bit_cnt == 3'd0) begin
        txreg <= (cmd == SEE_CMD_RDSR) ? status
               : mem[addr[SEE_ADDR_W-1:0]];
      end else begin
        txreg <= {txreg[6:0], 1'b0};
      end
    end
  end

  assign bus.sdo    = txreg[7];
  assign bus.sdo_oe = live && state == SEE_D_RDATA;

  // Write latch, status bits and write cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wel              <= 1'b0;
      srwd             <= 1'b0;
      block_protect_hi <= 1'b0;
      block_protect_lo <= 1'b0;
      wbuf             <= 8'h00;
      wpend            <= 1'b0;
      wtimer           <= 16'h0000;
    end else begin
      if (wtimer != 16'h0000) begin
        wtimer <= wtimer - 16'd1;
      end
      if (byte_done && state == SEE_D_CMD && !write_busy) begin
        if (next_byte == SEE_CMD_WREN) wel <= 1'b1;
        if (next_byte == SEE_CMD_WRDI) wel <= 1'b0;
      end
      if (byte_done && state == SEE_D_SRW && wel && !write_busy) begin
        if (!(srwd && !bus.wprot_b)) begin
          srwd             <= next_byte[SEE_SR_SRWD];
          block_protect_hi <= next_byte[SEE_SR_BPHI];
          block_protect_lo <= next_byte[SEE_SR_BPLO];
        end
        wel    <= 1'b0;
        wtimer <= 16'(WRITE_CYC);
      end
      if (byte_done && state == SEE_D_WDATA) begin
        wbuf  <= next_byte;
        wpend <= wel && !write_busy;
      end
      // Byte commits on deselect, unlike a status write, which commits at its eighth sck rise
      if (wpend && bus.sel_b) begin
        wpend  <= 1'b0;
        wel    <= 1'b0;
        wtimer <= 16'(WRITE_CYC);
      end
    end
  end

  // Array write; protected top region by block-protect bits
  function automatic logic see_protected(input logic [SEE_ADDR_W-1:0] a,
                                         input logic hi, input logic lo);
    case ({hi, lo})
      2'b01:   see_protected = a[14] & a[13];
      2'b10:   see_protected = a[14];
      2'b11:   see_protected = 1'b1;
      default: see_protected = 1'b0;
    endcase
  endfunction

  always_ff @(posedge ref_clk) begin
    if (wpend && bus.sel_b &&
        !see_protected(addr[SEE_ADDR_W-1:0], block_protect_hi, block_protect_lo)) begin
      mem[addr[SEE_ADDR_W-1:0]] <= wbuf;
    end
  end

  assign write_busy = (wtimer != 16'h0000);
  assign active     = live || write_busy;
  always_comb begin
    status = SEE_SR_RESET;
    status[SEE_SR_WIP]  = write_busy;
    status[SEE_SR_WEL]  = wel;
    status[SEE_SR_BPLO] = block_protect_lo;
    status[SEE_SR_BPHI] = block_protect_hi;
    status[SEE_SR_SRWD] = srwd;
  end
endmodule
`default_nettype wire

// >>> see_host.sv
// SPI master end: one byte per request, frame closed by last, mode 0,0 or 1,1.
// Assumes the device samples pins on the same ref_clk.
`timescale 1ns/1ps
`default_nettype none
module see_host
  import see_pkg::*;
#(
  parameter int unsigned SCK_DIV = SEE_SCK_DIV
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Serial pins
  see_if.host             bus,
  // User side
  input  wire logic       mode_cpol,
  input  wire logic       wprot_level,
  input  wire logic       pause_req,
  input  wire logic       start,
  input  wire logic       last,
  input  wire logic [7:0] tx_byte,
  output logic            ready,
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  initial begin
    if (SCK_DIV < 2) $error("SCK_DIV must be at least 2");
  end

  see_host_state_t state;
  logic [15:0]     div;
  logic [2:0]      bit_cnt;
  logic [7:0]      sh;
  logic            end_frame;
  logic            sck_lvl;
  logic            pause_q;
  logic            sck_pin;
  wire             tick = (div == 16'(SCK_DIV - 1));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div <= 16'h0000;
    end else begin
      div <= (tick || state == SEE_H_IDLE) ? 16'h0000 : div + 16'd1;
    end
  end

  // Pause enters and leaves only while sck is low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pause_q <= 1'b0;
    end else if (!sck_pin && !bus.sel_b) begin
      pause_q <= pause_req;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= SEE_H_IDLE;
      bus.sel_b <= 1'b1;
      sck_lvl   <= 1'b0;
      bit_cnt   <= 3'd0;
      sh        <= 8'h00;
      end_frame <= 1'b0;
      rx_valid  <= 1'b0;
      rx_byte   <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      case (state)
        SEE_H_IDLE: begin
          sck_lvl <= 1'b0;
          if (start) begin
            bus.sel_b <= 1'b0;
            sh        <= tx_byte;
            end_frame <= last;
            bit_cnt   <= 3'd0;
            state     <= SEE_H_SEL;
          end
        end
        SEE_H_SEL: begin
          if (tick) state <= SEE_H_LOW;
        end
        SEE_H_LOW: begin
          if (tick && !pause_q) begin
            sck_lvl <= 1'b1;
            state   <= SEE_H_HIGH;
          end
        end
        SEE_H_HIGH: begin
          if (tick) begin
            sck_lvl <= 1'b0;
            sh      <= {sh[6:0], bus.sdo_line};
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              rx_valid <= 1'b1;
              rx_byte  <= {sh[6:0], bus.sdo_line};
              state    <= end_frame ? SEE_H_DONE : SEE_H_IDLE;
            end else begin
              state <= SEE_H_LOW;
            end
          end
        end
        default: begin
          if (tick) begin
            bus.sel_b <= 1'b1;
            state     <= SEE_H_IDLE;
          end
        end
      endcase
      // Chained byte keeps select low
      if (state == SEE_H_IDLE && !start && !bus.sel_b && !end_frame) begin
        bus.sel_b <= 1'b0;
      end
    end
  end

  // Idle level set by mode; mode 1,1 gets a leading fall and no trailing one
  assign sck_pin     = (state == SEE_H_LOW || state == SEE_H_HIGH) ? sck_lvl : mode_cpol;
  assign bus.sck     = sck_pin;
  assign bus.sdi     = sh[7];
  assign bus.pause_b = !pause_q;
  assign bus.wprot_b = wprot_level;
  assign ready       = (state == SEE_H_IDLE);
endmodule
`default_nettype wire

// >>> see_if.sv
// Serial pins between the master and the EEPROM front end.
// Output line resolves from the device's enable; undriven reads high.
`timescale 1ns/1ps
`default_nettype none
interface see_if;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sel_b;
  logic pause_b;
  logic wprot_b;
  logic sdo_line;
  assign sdo_line = sdo_oe ? sdo : 1'b1;
  modport dev (input sck, sdi, sel_b, pause_b, wprot_b, output sdo, sdo_oe);
  modport host (output sck, sdi, sel_b, pause_b, wprot_b, input sdo_line);
endinterface
`default_nettype wire

// >>> see_pkg.sv
// Shared constants and types for the serial EEPROM front end.
// Assumes both ends run on one ref_clk; serial clock is a sampled pin.
package see_pkg;
  localparam int unsigned SEE_ARRAY_BYTES = 32768;
  localparam int unsigned SEE_ADDR_W      = 15;
  localparam int unsigned SEE_ID_BYTES    = 64;
  localparam int unsigned SEE_BYTE_W      = 8;
  localparam logic [7:0]  SEE_CMD_WREN    = 8'h06;
  localparam logic [7:0]  SEE_CMD_WRDI    = 8'h04;
  localparam logic [7:0]  SEE_CMD_RDSR    = 8'h05;
  localparam logic [7:0]  SEE_CMD_WRSR    = 8'h01;
  localparam logic [7:0]  SEE_CMD_READ    = 8'h03;
  localparam logic [7:0]  SEE_CMD_WRITE   = 8'h02;
  localparam int unsigned SEE_SR_WIP      = 0;
  localparam int unsigned SEE_SR_WEL      = 1;
  localparam int unsigned SEE_SR_BPLO     = 2;
  localparam int unsigned SEE_SR_BPHI     = 3;
  localparam int unsigned SEE_SR_SRWD     = 7;
  localparam logic [7:0]  SEE_SR_RESET    = 8'h00;
  localparam int unsigned SEE_WRITE_CYC   = 64;
  localparam int unsigned SEE_SCK_DIV     = 4;
  typedef enum logic [2:0] {
    SEE_D_CMD, SEE_D_ADDR, SEE_D_RDATA, SEE_D_WDATA, SEE_D_SRW, SEE_D_SINK
  } see_dev_state_t;
  typedef enum logic [2:0] {
    SEE_H_IDLE, SEE_H_SEL, SEE_H_LOW, SEE_H_HIGH, SEE_H_DONE
  } see_host_state_t;
endpackage

// >>> test_spi_eeprom_serial_front_end.sv
// Self-checking bench: host and device joined through the serial pins.
// Assumes one 200 MHz clock; expectations come from bench functions.
`timescale 1ns/1ps
`default_nettype none
module test_spi_eeprom_serial_front_end import see_pkg::*;;
  logic ref_clk = 1'b0, rst_b = 1'b0, mode_cpol = 1'b0, wprot_level = 1'b1;
  logic pause_req = 1'b0, start = 1'b0, last = 1'b0, ready, rx_valid;
  logic active, write_busy, block_protect_hi, block_protect_lo;
  logic [7:0]  tx_byte = 8'h00, rx_byte, rx, d, d0;
  logic [14:0] a;
  logic [7:0]  q[$];
  bit          s;
  int          n_errors = 0, compares = 0, seed = 51901, i, m;
  see_if bus ();
  see_device #(.WRITE_CYC(8)) see_device_inst (.ref_clk, .rst_b, .bus(bus), .active,
    .write_busy, .block_protect_hi, .block_protect_lo);
  see_host see_host_inst (.ref_clk, .rst_b, .bus(bus), .mode_cpol, .wprot_level,
    .pause_req, .start, .last, .tx_byte, .ready, .rx_valid, .rx_byte);
  see_asserts see_asserts_inst (.ref_clk, .rst_b, .sck(bus.sck), .sdi(bus.sdi),
    .sdo(bus.sdo), .sdo_oe(bus.sdo_oe), .sel_b(bus.sel_b), .pause_b(bus.pause_b),
    .active, .write_busy);
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  function automatic bit prot(input logic [1:0] bp, input logic [14:0] ad);
    case (bp)
      2'h1: prot = ad[14:13] == 2'h3;
      2'h2: prot = ad[14];
      2'h3: prot = 1'b1;
      default: prot = 1'b0;
    endcase
  endfunction
  // Sends q as one frame; optional pause inside the last byte
  task automatic frame(input bit pz);
    int k, n;
    for (k = 0; k < q.size(); k++) begin
      n = 0;
      while (ready !== 1'b1 && n < 300) begin
        @(posedge ref_clk); #1; n++;
      end
      start = 1'b1;
      tx_byte = q[k];
      last = (k == q.size() - 1);
      @(posedge ref_clk); #1;
      start = 1'b0;
      if (pz && last) begin
        repeat (20) @(posedge ref_clk);
        #1 pause_req = 1'b1;
        repeat (40) @(posedge ref_clk);
        #1 chk("paused", 8'h00, {6'h0, bus.sdo_oe, active});
        pause_req = 1'b0;
      end
      while (rx_valid !== 1'b1 && n < 600) begin
        @(posedge ref_clk); #1; n++;
      end
      if (rx_valid !== 1'b1) begin
        $display("ERROR frame_byte expected rx_valid seen timeout");
        n_errors++;
      end
      rx = rx_byte;
    end
    // Frame ends only once select is released and the host is idle again
    n = 0;
    while (ready !== 1'b1 && n < 300) begin
      @(posedge ref_clk); #1; n++;
    end
    q.delete();
  endtask
  task automatic wait_write(output bit seen);
    int n;
    n = 0;
    while (write_busy !== 1'b1 && n < 30) begin
      @(posedge ref_clk); #1; n++;
    end
    seen = (write_busy === 1'b1);
    while (write_busy !== 1'b0 && n < 100) begin
      @(posedge ref_clk); #1; n++;
    end
  endtask
  task automatic wr(input logic [14:0] ad, input logic [7:0] dt, output bit seen);
    q = {SEE_CMD_WREN};
    frame(1'b0);
    q = {SEE_CMD_WRITE, 8'(ad[14:8]), ad[7:0], dt};
    frame(1'b0);
    wait_write(seen);
  endtask
  task automatic rd(input logic [14:0] ad, input bit pz);
    q = {SEE_CMD_READ, 8'(ad[14:8]), ad[7:0], 8'h00};
    frame(pz);
  endtask
  task automatic wrsr(input logic [7:0] v);
    bit seen;
    q = {SEE_CMD_WREN};
    frame(1'b0);
    q = {SEE_CMD_WRSR, v};
    frame(1'b0);
    wait_write(seen);
    chk("wrsr_cycle", 8'h01, {7'h0, seen});
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk("unarmed", 8'h00, {6'h0, bus.sdo_oe, active});
    for (m = 0; m < 2; m++) begin
      mode_cpol = m[0];
      for (i = 0; i < 4; i++) begin
        a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7FFF : 15'($random(seed));
        d = 8'($random(seed));
        wr(a, d, s);
        chk("write_cycle", 8'h01, {7'h0, s});
        rd(a, i == 3);
        chk("read_back", d, rx);
      end
      $display("Mode %0d test done", m);
    end
    q = {SEE_CMD_WREN};
    frame(1'b0);
    q = {SEE_CMD_RDSR, 8'h00};
    frame(1'b0);
    chk("status", 8'h02, rx);
    $display("Status test done");
    wrsr(8'h8C);
    chk("bp_set", 8'h03, {6'h0, block_protect_hi, block_protect_lo});
    wprot_level = 1'b0;
    wrsr(8'h84);
    chk("bp_frozen", 8'h03, {6'h0, block_protect_hi, block_protect_lo});
    wprot_level = 1'b1;
    for (i = 0; i < 3; i++) begin
      if (i == 1) wrsr(8'h04);
      a = i[0] ? 15'h7FFF : 15'h0000;
      rd(a, 1'b0);
      d0 = rx;
      wr(a, ~d0, s);
      rd(a, 1'b0);
      chk("prot_region", prot(i ? 2'h1 : 2'h3, a) ? d0 : ~d0, rx);
    end
    chk("bp_quarter", 8'h01, {6'h0, block_protect_hi, block_protect_lo});
    $display("Protection test done");
    report_and_stop();
  end
  // About 44 frames of under 400 cycles each; generous margin
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
endmodule
`default_nettype wire
